/* src/meru_pkg.sv */
package meru_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned BE_W        = 4;

    // register byte offsets
    localparam logic [7:0]  OFS_STATUS   = 8'h00;
    localparam logic [7:0]  OFS_SUPPRESS = 8'h04;
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h08;
    localparam logic [7:0]  OFS_ATTR     = 8'h0c;
    localparam logic [7:0]  OFS_ADDR     = 8'h10;
    localparam logic [7:0]  OFS_SBE      = 8'h14;

    // status bit positions; the four error classes are also shared by suppress and enable
    localparam int unsigned REPEAT_BIT  = 0;
    localparam int unsigned CALIB_BIT   = 24;
    localparam int unsigned MULTI_BIT   = 28;
    localparam int unsigned SINGLE_BIT  = 29;
    localparam int unsigned SELECT_BIT  = 31;

    // capture attribute fields
    localparam int unsigned BEAT_LO     = 1;
    localparam int unsigned BEAT_W      = 3;
    localparam int unsigned SIZE_LO     = 5;
    localparam int unsigned SIZE_W      = 3;
    localparam int unsigned SRC_LO      = 11;
    localparam int unsigned SRC_W       = 5;
    localparam int unsigned TYPE_LO     = 18;
    localparam int unsigned TYPE_W      = 2;
    localparam int unsigned VALID_BIT   = 31;

    // single-bit management fields
    localparam int unsigned THR_LO      = 8;
    localparam int unsigned CNT_LO      = 24;
    localparam int unsigned SBE_W       = 8;

    // implemented bits of each register; the rest read as zero
    localparam logic [31:0] STATUS_MASK = 32'hb1000001;
    localparam logic [31:0] CLASS_MASK  = 32'hb1000000;
    localparam logic [31:0] ATTR_MASK   = 32'h800cf8ee;
    localparam logic [31:0] SBE_MASK    = 32'hff00ff00;
    localparam logic [31:0] RST_REG     = 32'h00000000;

    typedef enum logic {BUS_IDLE, BUS_ANSWER} meru_bus_e;

endpackage

/* src/meru_cap_if.sv */
`timescale 1ns/100ps
interface meru_cap_if
    import meru_pkg::*;
();
    logic               capture_en;
    logic [BEAT_W-1:0]  beat;
    logic [SIZE_W-1:0]  size;
    logic [SRC_W-1:0]   source;
    logic [TYPE_W-1:0]  ttype;
    logic [DATA_W-1:0]  addr;
    logic               attr_we;
    logic               addr_we;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  wmask;
    logic [DATA_W-1:0]  attr_q;
    logic [DATA_W-1:0]  addr_q;
    logic               valid;

    modport ctl (output capture_en, beat, size, source, ttype, addr,
                 output attr_we, addr_we, wdata, wmask,
                 input  attr_q, addr_q, valid);
    modport cap (input  capture_en, beat, size, source, ttype, addr,
                 input  attr_we, addr_we, wdata, wmask,
                 output attr_q, addr_q, valid);
endinterface

/* src/meru_capture.sv */
`timescale 1ns/100ps
module meru_capture
    import meru_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    meru_cap_if.cap  cap
);

    logic [DATA_W-1:0] attr_r;
    logic [DATA_W-1:0] attr_nxt;
    logic [DATA_W-1:0] addr_r;
    logic [DATA_W-1:0] addr_nxt;

    // software writes first, a capture overrides them in the same cycle
    always_comb begin
        attr_nxt = attr_r;
        addr_nxt = addr_r;
        if (cap.attr_we) begin
            attr_nxt = (attr_r & ~(cap.wmask & ATTR_MASK))
                     | (cap.wdata & cap.wmask & ATTR_MASK);
        end
        if (cap.addr_we) begin
            addr_nxt = (addr_r & ~cap.wmask) | (cap.wdata & cap.wmask);
        end
        // first error wins; a capture also beats a same-cycle clear of
        // valid, so an error racing software is not lost
        if (cap.capture_en
            && !(attr_r[VALID_BIT] && attr_nxt[VALID_BIT])) begin // [R22]
            attr_nxt = RST_REG;
            attr_nxt[BEAT_LO +: BEAT_W] = cap.beat;     // [R12]
            attr_nxt[SIZE_LO +: SIZE_W] = cap.size;     // [R13]
            attr_nxt[SRC_LO +: SRC_W]   = cap.source;   // [R14]
            attr_nxt[TYPE_LO +: TYPE_W] = cap.ttype;    // [R15]
            attr_nxt[VALID_BIT]         = 1'b1;         // [R16]
            addr_nxt                    = cap.addr;     // [R17]
        end
    end

    // capture storage
    always_ff @(posedge clk) begin
        if (reset) begin
            attr_r <= RST_REG;
            addr_r <= RST_REG;
        end else begin
            attr_r <= attr_nxt;
            addr_r <= addr_nxt;
        end
    end

    assign cap.attr_q = attr_r;
    assign cap.addr_q = addr_r;
    assign cap.valid  = attr_r[VALID_BIT];

    chk_capture_hold: assert property ( // [R22]
        @(posedge clk) disable iff (reset)
        cap.valid && !cap.attr_we && !cap.addr_we
        |=> $stable(cap.addr_q) && $stable(cap.attr_q))
        else $error("capture record changed while valid");

    chk_capture_load: assert property ( // [R16]
        @(posedge clk) disable iff (reset)
        cap.capture_en && !cap.valid
        |=> cap.valid && (cap.addr_q == $past(cap.addr))
            && (cap.attr_q[SRC_LO +: SRC_W] == $past(cap.source)))
        else $error("error record not captured");

endmodule

/* src/meru_error_report.sv */
// How it works
// (R1) writing one clears a status flag
// (R2) suppressed classes never flag nor capture
// (R3) bit 0 flags a repeated error type
// (R4) bit 24 flags calibration error
// (R5) bit 28 flags multi-bit ecc error
// (R6) bit 29 flags single-bit threshold reached
// (R7) bit 31 flags memory select error
// (R8) suppress bits 24, 28, 29, 31
// (R9) multi-bit needs ecc enabled, not suppressed
// (R10) interrupt follows enabled error conditions
// (R11) interrupt enable bits 24, 28, 29, 31
// (R12) capture bits 1-3 hold beat index
// (R13) capture bits 5-7 hold transfer size
// (R14) capture bits 11-15 hold master source
// (R15) capture bits 18-19 hold access type
// (R16) capture bit 31 marks valid record
// (R17) address capture holds low 32 bits
// (R18) threshold sits in bits 8-15
// (R19) counter bits 24-31 count corrected errors
// (R20) counter returns to zero at threshold
// (R21) software clears counter after handling
// (R22) valid record is not overwritten
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module meru_error_report
    import meru_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [BE_W-1:0]   avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              ecc_check_en,
    input  wire logic              calib_err,
    input  wire logic              multi_bit_err,
    input  wire logic              single_bit_err,
    input  wire logic              select_err,
    input  wire logic [BEAT_W-1:0] err_beat,
    input  wire logic [SIZE_W-1:0] err_size,
    input  wire logic [SRC_W-1:0]  err_source,
    input  wire logic [TYPE_W-1:0] err_type,
    input  wire logic [DATA_W-1:0] err_addr,
    output logic                   irq
);

    meru_bus_e         state_r;
    meru_bus_e         state_nxt;
    logic [DATA_W-1:0] readdata_r;
    logic [DATA_W-1:0] readdata_nxt;
    logic [DATA_W-1:0] wmask;
    logic              wr_take;
    logic              sel_status;
    logic              sel_suppress;
    logic              sel_irq_en;
    logic              sel_attr;
    logic              sel_addr;
    logic              sel_sbe;

    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] status_nxt;
    logic [DATA_W-1:0] status_w1c;
    logic [DATA_W-1:0] set_vec;
    logic              repeat_hit;
    logic [DATA_W-1:0] suppress_r;
    logic [DATA_W-1:0] irq_en_r;
    logic              irq_r;

    logic              calib_evt;
    logic              multi_evt;
    logic              single_evt;
    logic              select_evt;
    logic              sbe_obs;
    logic [SBE_W-1:0]  thr_r;
    logic [SBE_W-1:0]  cnt_r;
    logic [SBE_W-1:0]  thr_base;
    logic [SBE_W-1:0]  cnt_base;
    logic [SBE_W-1:0]  cnt_inc;
    logic [SBE_W-1:0]  cnt_nxt;
    logic [DATA_W-1:0] sbe_word;
    logic [DATA_W-1:0] sbe_written;

    meru_cap_if cap_bus ();

    // byte enables widened to a bit mask, one lane per generate step
    genvar lane;
    generate
        for (lane = 0; lane < BE_W; lane++) begin : g_lane
            assign wmask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
        end
    endgenerate

    // address decode; misaligned or unknown addresses select nothing
    assign sel_status   = (avs_address == OFS_STATUS);
    assign sel_suppress = (avs_address == OFS_SUPPRESS);
    assign sel_irq_en   = (avs_address == OFS_IRQ_EN);
    assign sel_attr     = (avs_address == OFS_ATTR);
    assign sel_addr     = (avs_address == OFS_ADDR);
    assign sel_sbe      = (avs_address == OFS_SBE);

    // every access waits exactly one cycle, so read data are registered
    // and writes land at the edge where waitrequest is seen low
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_nxt = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                state_nxt = BUS_IDLE;
            end
        endcase
    end

    assign avs_waitrequest = (avs_read || avs_write)
                           && (state_r == BUS_IDLE);
    assign wr_take         = avs_write && (state_r == BUS_ANSWER);

    // bus handshake state
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= BUS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // read mux; unmapped offsets answer zero
    always_comb begin
        readdata_nxt = readdata_r;
        if (avs_read && (state_r == BUS_IDLE)) begin
            if (sel_status) begin
                readdata_nxt = status_r;
            end else if (sel_suppress) begin
                readdata_nxt = suppress_r;
            end else if (sel_irq_en) begin
                readdata_nxt = irq_en_r;
            end else if (sel_attr) begin
                readdata_nxt = cap_bus.attr_q;
            end else if (sel_addr) begin
                readdata_nxt = cap_bus.addr_q;
            end else if (sel_sbe) begin
                readdata_nxt = sbe_word;
            end else begin
                readdata_nxt = RST_REG;
            end
        end
    end

    // read data register, held until the next read
    always_ff @(posedge clk) begin
        if (reset) begin
            readdata_r <= RST_REG;
        end else begin
            readdata_r <= readdata_nxt;
        end
    end

    assign avs_readdata = readdata_r;

    // class qualification; a suppressed class is invisible downstream
    assign calib_evt  = calib_err && !suppress_r[CALIB_BIT];      // [R2] [R8]
    assign multi_evt  = multi_bit_err && ecc_check_en
                      && !suppress_r[MULTI_BIT];                  // [R9] [R8]
    assign sbe_obs    = single_bit_err && ecc_check_en
                      && !suppress_r[SINGLE_BIT];                 // [R2] [R8]
    assign select_evt = select_err && !suppress_r[SELECT_BIT];    // [R2] [R8]

    // single-bit threshold and counter, with a same-cycle software write
    // folded in first so a counted error is never lost under a write
    assign sbe_word    = ({cnt_r, 8'h00, thr_r, 8'h00}) & SBE_MASK;
    assign sbe_written = (sbe_word & ~(wmask & SBE_MASK))
                       | (avs_writedata & wmask & SBE_MASK);
    assign thr_base    = (wr_take && sel_sbe)
                       ? sbe_written[THR_LO +: SBE_W] : thr_r;    // [R18]
    assign cnt_base    = (wr_take && sel_sbe)
                       ? sbe_written[CNT_LO +: SBE_W] : cnt_r;    // [R21]
    assign cnt_inc     = SBE_W'(cnt_base + 8'h01);

    always_comb begin
        cnt_nxt    = cnt_base;
        single_evt = 1'b0;
        if (sbe_obs) begin
            if (cnt_inc == thr_base) begin
                cnt_nxt    = '0;                                  // [R20]
                single_evt = 1'b1;                                // [R19]
            end else begin
                cnt_nxt    = cnt_inc;                             // [R19]
            end
        end
    end

    // threshold and counter storage
    always_ff @(posedge clk) begin
        if (reset) begin
            thr_r <= '0;
            cnt_r <= '0;
        end else begin
            thr_r <= thr_base;
            cnt_r <= cnt_nxt;
        end
    end

    // status: hardware sets win over a one written in the same cycle
    always_comb begin
        set_vec             = RST_REG;
        set_vec[CALIB_BIT]  = calib_evt;                          // [R4]
        set_vec[MULTI_BIT]  = multi_evt;                          // [R5]
        set_vec[SINGLE_BIT] = single_evt;                         // [R6]
        set_vec[SELECT_BIT] = select_evt;                         // [R7]
        repeat_hit          = |(set_vec & status_r & CLASS_MASK); // [R3]
        set_vec[REPEAT_BIT] = repeat_hit;                         // [R3]
        status_w1c          = RST_REG;
        if (wr_take && sel_status) begin
            status_w1c = avs_writedata & wmask & STATUS_MASK;     // [R1]
        end
        status_nxt = ((status_r & ~status_w1c) | set_vec) & STATUS_MASK;
    end

    // status register
    always_ff @(posedge clk) begin
        if (reset) begin
            status_r <= RST_REG;
        end else begin
            status_r <= status_nxt;
        end
    end

    // suppress and interrupt enable registers, byte-lane writes
    always_ff @(posedge clk) begin
        if (reset) begin
            suppress_r <= RST_REG;
        end else if (wr_take && sel_suppress) begin
            suppress_r <= ((suppress_r & ~wmask)
                       | (avs_writedata & wmask)) & CLASS_MASK;   // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_r <= RST_REG;
        end else if (wr_take && sel_irq_en) begin
            irq_en_r <= ((irq_en_r & ~wmask)
                     | (avs_writedata & wmask)) & CLASS_MASK;     // [R11]
        end
    end

    // interrupt is a level from flagged and enabled classes; registered
    // so the line never glitches with the status decode
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & irq_en_r & CLASS_MASK);         // [R10] [R11]
        end
    end

    assign irq = irq_r;

    // capture request: calibration carries no transaction, so it only flags
    assign cap_bus.capture_en = multi_evt || single_evt
                              || select_evt;                      // [R2]
    assign cap_bus.beat       = err_beat;                         // [R12]
    assign cap_bus.size       = err_size;                         // [R13]
    assign cap_bus.source     = err_source;                       // [R14]
    assign cap_bus.ttype      = err_type;                         // [R15]
    assign cap_bus.addr       = err_addr;                         // [R17]
    assign cap_bus.attr_we    = wr_take && sel_attr;
    assign cap_bus.addr_we    = wr_take && sel_addr;
    assign cap_bus.wdata      = avs_writedata;
    assign cap_bus.wmask      = wmask;

    meru_capture u_capture (
        .clk   (clk),
        .reset (reset),
        .cap   (cap_bus.cap)
    );

    chk_w1c_clear: assert property (@(posedge clk) disable iff (reset) // [R1]
        status_w1c[MULTI_BIT] && !multi_evt |=> !status_r[MULTI_BIT])
        else $error("written one did not clear multi-bit flag");

    chk_suppress_block: assert property ( // [R2]
        @(posedge clk) disable iff (reset)
        suppress_r[SELECT_BIT] && !status_r[SELECT_BIT]
        |=> !status_r[SELECT_BIT])
        else $error("suppressed select error set its flag");

    chk_repeat_flag: assert property ( // [R3]
        @(posedge clk) disable iff (reset)
        select_err && !suppress_r[SELECT_BIT] && status_r[SELECT_BIT]
        |=> status_r[REPEAT_BIT])
        else $error("repeated error not flagged");

    chk_multi_gate: assert property (@(posedge clk) disable iff (reset) // [R9]
        multi_bit_err && !ecc_check_en && !status_r[MULTI_BIT]
        |=> !status_r[MULTI_BIT])
        else $error("multi-bit flagged with ecc checking off");

    chk_irq_follow: assert property ( // [R10]
        @(posedge clk) disable iff (reset)
        (calib_err && !suppress_r[CALIB_BIT] && irq_en_r[CALIB_BIT])
        ##1 irq_en_r[CALIB_BIT] |=> irq)
        else $error("enabled calibration error gave no interrupt");

    chk_count_wrap: assert property ( // [R20]
        @(posedge clk) disable iff (reset)
        sbe_obs && (cnt_inc == thr_base)
        |=> (cnt_r == '0) && status_r[SINGLE_BIT])
        else $error("counter did not wrap and report at threshold");

    chk_calib_set: assert property ( // [R4]
        @(posedge clk) disable iff (reset)
        calib_err && !suppress_r[CALIB_BIT]
        |=> status_r[CALIB_BIT])
        else $error("calibration error not flagged");

    chk_multi_set: assert property ( // [R5]
        @(posedge clk) disable iff (reset)
        multi_bit_err && ecc_check_en && !suppress_r[MULTI_BIT]
        |=> status_r[MULTI_BIT])
        else $error("multi-bit error not flagged");

    chk_select_set: assert property ( // [R7]
        @(posedge clk) disable iff (reset)
        select_err && !suppress_r[SELECT_BIT]
        |=> status_r[SELECT_BIT])
        else $error("select error not flagged");

    chk_select_irq: assert property ( // [R10]
        @(posedge clk) disable iff (reset)
        status_r[SELECT_BIT] && irq_en_r[SELECT_BIT]
        |=> irq)
        else $error("enabled select flag gave no interrupt");

    chk_capture_gate: assert property ( // [R2]
        @(posedge clk) disable iff (reset)
        (suppress_r & CLASS_MASK) == CLASS_MASK && !cap_bus.valid
        && !cap_bus.attr_we |=> !cap_bus.valid)
        else $error("suppressed error was captured");

endmodule

/* tb/meru_err_src.sv */
`timescale 1ns/100ps
// controller error sources: one-cycle pulses carrying transaction info
module meru_err_src
    import meru_pkg::*;
(
    input  wire logic              clk,
    output logic                   calib_err,
    output logic                   multi_bit_err,
    output logic                   single_bit_err,
    output logic                   select_err,
    output logic      [BEAT_W-1:0] err_beat,
    output logic      [SIZE_W-1:0] err_size,
    output logic      [SRC_W-1:0]  err_source,
    output logic      [TYPE_W-1:0] err_type,
    output logic      [DATA_W-1:0] err_addr
);
    initial begin
        {calib_err, multi_bit_err, single_bit_err, select_err} = 4'h0;
        {err_beat, err_size, err_source, err_type} = 13'h0000;
        err_addr = 32'h00000000;
    end

    // cls is {calib, multi, single, select}; info is {beat,size,src,type}
    // info is inverted after the pulse so late sampling shows up
    task automatic fire(input logic [3:0] cls, input logic [12:0] info,
                        input logic [31:0] a);
        @(posedge clk);
        {calib_err, multi_bit_err, single_bit_err, select_err} <= cls;
        {err_beat, err_size, err_source, err_type} <= info;
        err_addr <= a;
        @(posedge clk);
        {calib_err, multi_bit_err, single_bit_err, select_err} <= 4'h0;
        {err_beat, err_size, err_source, err_type} <= ~info;
        err_addr <= ~a;
    endtask
endmodule

/* tb/meru_error_report_tb.sv */
`timescale 1ns/100ps
module meru_error_report_tb;
    import meru_pkg::*;
    logic              clk;
    logic              reset;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [BE_W-1:0]   avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              ecc_check_en;
    logic              calib_err, multi_bit_err, single_bit_err, select_err;
    logic [BEAT_W-1:0] err_beat;
    logic [SIZE_W-1:0] err_size;
    logic [SRC_W-1:0]  err_source;
    logic [TYPE_W-1:0] err_type;
    logic [DATA_W-1:0] err_addr;
    logic              irq;
    int                error_cnt;
    int                n_tests;
    int                cyc;

    meru_error_report dut_u (
        .clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ecc_check_en(ecc_check_en), .calib_err(calib_err),
        .multi_bit_err(multi_bit_err), .single_bit_err(single_bit_err),
        .select_err(select_err), .err_beat(err_beat), .err_size(err_size),
        .err_source(err_source), .err_type(err_type), .err_addr(err_addr),
        .irq(irq));

    meru_err_src src_u (
        .clk(clk), .calib_err(calib_err), .multi_bit_err(multi_bit_err),
        .single_bit_err(single_bit_err), .select_err(select_err),
        .err_beat(err_beat), .err_size(err_size), .err_source(err_source),
        .err_type(err_type), .err_addr(err_addr));

    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        // no local limit: only the bench timeout ends a stuck wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, 4'hf, q);
        chk(nm, q, exp);
    endtask

    // irq is registered one edge behind status
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    function automatic logic [31:0] attr_of(input logic [12:0] i);
        return 32'h80000000 | (32'(i[1:0]) << TYPE_LO)
             | (32'(i[6:2]) << SRC_LO) | (32'(i[9:7]) << SIZE_LO)
             | (32'(i[12:10]) << BEAT_LO);
    endfunction

    task automatic t_reset_access();
        for (int o = 0; o < 7; o++)
            rd("reset value", 8'(o * 4), 32'h00000000);
        wr(OFS_SUPPRESS, 32'hffffffff);
        wr(OFS_IRQ_EN, 32'hffffffff);
        wr(OFS_SBE, 32'hffffffff);
        wr(OFS_STATUS, 32'hffffffff);
        rd("suppress", OFS_SUPPRESS, CLASS_MASK);
        rd("irq_enable", OFS_IRQ_EN, CLASS_MASK);
        rd("sbe", OFS_SBE, SBE_MASK);
        rd("status w1c", OFS_STATUS, 32'h00000000);
        wr(OFS_SUPPRESS, 32'h00000000);
        wr(OFS_SBE, 32'h00000000);
    endtask

    task automatic t_select();
        src_u.fire(4'h1, {3'h5, 3'h3, 5'h0d, 2'h3}, 32'hdeadbeef);
        chk("irq early", {31'h0, irq}, 32'h0);
        rd("status sel", OFS_STATUS, 32'h80000000);
        rd("attr sel", OFS_ATTR, attr_of({3'h5, 3'h3, 5'h0d, 2'h3}));
        rd("addr sel", OFS_ADDR, 32'hdeadbeef);
        irq_is(1'b1);
        src_u.fire(4'h1, {3'h2, 3'h1, 5'h04, 2'h1}, 32'h12345678);
        rd("status rep", OFS_STATUS, 32'h80000001);
        rd("attr kept", OFS_ATTR, attr_of({3'h5, 3'h3, 5'h0d, 2'h3}));
        rd("addr kept", OFS_ADDR, 32'hdeadbeef);
        wr(OFS_STATUS, 32'h00000001);
        rd("clr rep", OFS_STATUS, 32'h80000000);
        wr(OFS_STATUS, 32'h00000000);
        wr(OFS_STATUS, 32'h80000000, 4'h7);
        rd("zero keeps", OFS_STATUS, 32'h80000000);
        wr(OFS_STATUS, 32'h80000000);
        rd("clr sel", OFS_STATUS, 32'h00000000);
        irq_is(1'b0);
    endtask

    // size codes 0 to 3 and access types 1 to 3 reach the capture fields
    task automatic t_codes();
        logic [12:0] i;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_ATTR, 32'h00000000);
            i = {3'(k + 4), 3'(k), 5'(k * 7 + 1), 2'(k == 0 ? 1 : k)};
            src_u.fire(4'h4, i, 32'h0f0f0000 + 32'(k));
            rd("attr code", OFS_ATTR, attr_of(i));
            rd("addr code", OFS_ADDR, 32'h0f0f0000 + 32'(k));
        end
        wr(OFS_STATUS, 32'hffffffff);
        wr(OFS_ATTR, 32'h00000000);
    endtask

    task automatic t_suppress();
        wr(OFS_SUPPRESS, CLASS_MASK);
        src_u.fire(4'hf, 13'h1fff, 32'h55555555);
        rd("status supp", OFS_STATUS, 32'h00000000);
        rd("attr supp", OFS_ATTR, 32'h00000000);
        rd("sbe supp", OFS_SBE, 32'h00000000);
        irq_is(1'b0);
        wr(OFS_SUPPRESS, 32'h00000000);
        ecc_check_en <= 1'b0;
        src_u.fire(4'h6, 13'h0aaa, 32'h66666666);
        rd("status ecc off", OFS_STATUS, 32'h00000000);
        rd("attr ecc off", OFS_ATTR, 32'h00000000);
        ecc_check_en <= 1'b1;
    endtask

    task automatic t_classes();
        wr(OFS_IRQ_EN, 32'h00000000);
        src_u.fire(4'h8, 13'h0123, 32'h00000040);
        rd("status calib", OFS_STATUS, 32'h01000000);
        src_u.fire(4'h4, {3'h7, 3'h2, 5'h1f, 2'h2}, 32'h00000080);
        rd("status multi", OFS_STATUS, 32'h11000000);
        rd("attr multi", OFS_ATTR, attr_of({3'h7, 3'h2, 5'h1f, 2'h2}));
        irq_is(1'b0);
        wr(OFS_IRQ_EN, 32'h10000000);
        irq_is(1'b1);
        wr(OFS_IRQ_EN, 32'h01000000);
        irq_is(1'b1);
        wr(OFS_STATUS, 32'h11000000);
        wr(OFS_ATTR, 32'h00000000);
        irq_is(1'b0);
        src_u.fire(4'h8, 13'h1fff, 32'h00000040);
        irq_is(1'b1);
        rd("attr calib", OFS_ATTR, 32'h00000000);
        wr(OFS_STATUS, 32'h01000000);
    endtask

    task automatic t_threshold();
        wr(OFS_IRQ_EN, 32'h20000000);
        wr(OFS_SBE, 32'h00000300);
        repeat (2) src_u.fire(4'h2, 13'h0000, 32'h00000100);
        rd("count two", OFS_SBE, 32'h02000300);
        rd("no flag yet", OFS_STATUS, 32'h00000000);
        irq_is(1'b0);
        src_u.fire(4'h2, {3'h3, 3'h0, 5'h02, 2'h2}, 32'h00000200);
        rd("count wrap", OFS_SBE, 32'h00000300);
        rd("flag thr", OFS_STATUS, 32'h20000000);
        rd("attr thr", OFS_ATTR, attr_of({3'h3, 3'h0, 5'h02, 2'h2}));
        irq_is(1'b1);
        src_u.fire(4'h2, 13'h0000, 32'h00000300);
        rd("count one", OFS_SBE, 32'h01000300);
        wr(OFS_SBE, 32'h00000300);
        rd("count clr", OFS_SBE, 32'h00000300);
    endtask

    initial begin
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        reset = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        ecc_check_en = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset_access();
        t_select();
        t_codes();
        t_suppress();
        t_classes();
        t_threshold();
        stop_test();
    end
endmodule
